// File: hw/timer8_compare_output_ctc.sv
// 8-bit timer/counter with compare units, wave outputs and port override
`timescale 1ns/1ps

// Summary of operation
// - Force strobe applies selected action like match, in non-PWM modes only
// - Forced match leaves flags and counter alone
// - Counter write blocks matches next tick
// - Wave outputs kept across mode changes
// - Action selection used immediately, unbuffered
// - Reset clears wave outputs to zero
// - Nonzero action overrides port output value
// - Port override same in every mode
// - Action zero leaves wave output unchanged
// - New action governs from next match
// - Counting depends only on mode selection
// - Normal mode increments and wraps
// - Normal mode overflow flag at zero
// - Normal mode counter writable any time
// - Clear-on-match clears at compare A
// - Compare A unbuffered; missed match wraps
// - Compare flag A set every period
// - Toggle action halves clear-on-match frequency
// - Clear-on-match overflow at max to zero
// - Match flags set next tick; write-one clears
// - Counter write beats clear or count
// - Clock source zero stops the timer
module timer8_compare_output_ctc (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // Timer clock enable from the prescaler
  input  wire logic       timerTick,
  // Interrupt acknowledge from the core, one cycle
  input  wire logic       ovfIntAck,
  input  wire logic       cmpAIntAck,
  input  wire logic       cmpBIntAck,
  // Port pins A and B
  input  wire logic [1:0] portOutValue,
  input  wire logic [1:0] wavePinDirectionBit,
  output logic      [1:0] pinOut,
  output logic      [1:0] pinOe,
  // Flag levels for the interrupt controller
  output logic            overflowFlag,
  output logic            compareFlagA,
  output logic            compareFlagB
);

  timer8_pkg::timer_state_s state_r;
  timer8_pkg::timer_state_s state_nxt;
  timer8_pkg::reg_req_s     req;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Applies one compare action to a wave output
  function automatic logic applyAction(input logic cur, input logic [1:0] act);
    logic res;
    res = cur;
    case (act)
      timer8_pkg::ACT_TOGGLE: res = ~cur;
      timer8_pkg::ACT_CLEAR:  res = 1'b0;
      timer8_pkg::ACT_SET:    res = 1'b1;
      default:                res = cur;
    endcase
    return res;
  endfunction

  always_comb
  begin
    logic       nonPwm;
    logic       running;
    logic       hitA;
    logic       hitB;
    logic       cntWr;
    logic       forceA;
    logic       forceB;
    logic [7:0] nextCount;
    state_nxt = state_r;
    nonPwm    = (state_r.waveModeSel == timer8_pkg::MODE_NORMAL) ||
                (state_r.waveModeSel == timer8_pkg::MODE_CLR_MTCH);
    running   = timerTick && (state_r.clockSourceSel != timer8_pkg::CLK_STOP);
    cntWr     = req.wr && (req.addr == timer8_pkg::ADDR_COUNT);
    forceA    = req.wr && (req.addr == timer8_pkg::ADDR_CTRL_B) &&
                req.wdata[timer8_pkg::FORCE_A_BIT] && nonPwm;
    forceB    = req.wr && (req.addr == timer8_pkg::ADDR_CTRL_B) &&
                req.wdata[timer8_pkg::FORCE_B_BIT] && nonPwm;
    // Compare is live, not buffered, in the modes implemented here
    hitA      = running && !state_r.blockMatch &&
                (state_r.counterValue == state_r.compareValueA);
    hitB      = running && !state_r.blockMatch &&
                (state_r.counterValue == state_r.compareValueB);

    // Wave outputs change only by matches or forcing; mode writes never touch them
    if (hitA || forceA)
    begin
      state_nxt.waveOutputA = applyAction(state_r.waveOutputA, state_r.outputActionSelA);
    end
    if (hitB || forceB)
    begin
      state_nxt.waveOutputB = applyAction(state_r.waveOutputB, state_r.outputActionSelB);
    end

    // Counting sequence is a function of mode only
    nextCount = state_r.counterValue + 8'h01;
    if ((state_r.waveModeSel == timer8_pkg::MODE_CLR_MTCH) &&
        (state_r.counterValue == state_r.compareValueA))
    begin
      nextCount = timer8_pkg::COUNT_ZERO;
    end
    if (running)
    begin
      state_nxt.counterValue = nextCount;
    end

    // A tick consumes the block; a write mid-stop keeps it alive until the next tick
    if (running)
    begin
      state_nxt.blockMatch = 1'b0;
    end
    if (cntWr)
    begin
      state_nxt.counterValue = req.wdata;
      state_nxt.blockMatch   = 1'b1;
    end

    // Flags: matches latch now and post on the next tick; forced matches never post
    state_nxt.pendMatchA = running ? hitA : (state_r.pendMatchA || hitA);
    state_nxt.pendMatchB = running ? hitB : (state_r.pendMatchB || hitB);
    if (req.wr && (req.addr == timer8_pkg::ADDR_FLAGS))
    begin
      if (req.wdata[timer8_pkg::FLAG_OVF])
        state_nxt.overflowFlag = 1'b0;
      if (req.wdata[timer8_pkg::FLAG_CMPA])
        state_nxt.compareFlagA = 1'b0;
      if (req.wdata[timer8_pkg::FLAG_CMPB])
        state_nxt.compareFlagB = 1'b0;
    end
    if (ovfIntAck)
      state_nxt.overflowFlag = 1'b0;
    if (cmpAIntAck)
      state_nxt.compareFlagA = 1'b0;
    if (cmpBIntAck)
      state_nxt.compareFlagB = 1'b0;
    // Sets placed last so an event beats a clear in the same cycle
    if (running && state_r.pendMatchA)
      state_nxt.compareFlagA = 1'b1;
    if (running && state_r.pendMatchB)
      state_nxt.compareFlagB = 1'b1;
    if (running && !cntWr && (state_r.counterValue == timer8_pkg::COUNT_MAX) &&
        (nextCount == timer8_pkg::COUNT_ZERO))
      state_nxt.overflowFlag = 1'b1;

    // Control writes
    if (req.wr && (req.addr == timer8_pkg::ADDR_CTRL_A))
    begin
      state_nxt.outputActionSelA = req.wdata[timer8_pkg::ACT_A_LSB +: 2];
      state_nxt.outputActionSelB = req.wdata[timer8_pkg::ACT_B_LSB +: 2];
      state_nxt.waveModeSel      = req.wdata[2:0];
    end
    if (req.wr && (req.addr == timer8_pkg::ADDR_CTRL_B))
      state_nxt.clockSourceSel = req.wdata[2:0];
    if (req.wr && (req.addr == timer8_pkg::ADDR_CMP_A))
      state_nxt.compareValueA = req.wdata;
    if (req.wr && (req.addr == timer8_pkg::ADDR_CMP_B))
      state_nxt.compareValueB = req.wdata;

    // Read data stands only in the cycle after the strobe
    state_nxt.rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        timer8_pkg::ADDR_CTRL_A:
          state_nxt.rdata = {state_r.outputActionSelA, state_r.outputActionSelB, 1'b0,
                             state_r.waveModeSel};
        timer8_pkg::ADDR_CTRL_B:  state_nxt.rdata = {5'h00, state_r.clockSourceSel};
        timer8_pkg::ADDR_COUNT:   state_nxt.rdata = state_r.counterValue;
        timer8_pkg::ADDR_CMP_A:   state_nxt.rdata = state_r.compareValueA;
        timer8_pkg::ADDR_CMP_B:   state_nxt.rdata = state_r.compareValueB;
        timer8_pkg::ADDR_FLAGS:
          state_nxt.rdata = {5'h00, state_r.compareFlagB, state_r.compareFlagA,
                             state_r.overflowFlag};
        timer8_pkg::ADDR_STATUS:
          state_nxt.rdata = {6'h00, state_r.waveOutputB, state_r.waveOutputA};
        default:                  state_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign regRdata     = state_r.rdata;
  assign overflowFlag = state_r.overflowFlag;
  assign compareFlagA = state_r.compareFlagA;
  assign compareFlagB = state_r.compareFlagB;

  // Override is mode independent; direction stays with the port
  assign pinOut[0] = (state_r.outputActionSelA != timer8_pkg::ACT_NONE) ?
                     state_r.waveOutputA : portOutValue[0];
  assign pinOut[1] = (state_r.outputActionSelB != timer8_pkg::ACT_NONE) ?
                     state_r.waveOutputB : portOutValue[1];
  assign pinOe     = wavePinDirectionBit;

endmodule

// File: hw/timer8_pkg.sv
// Package for the 8-bit compare timer: register map, fields, modes and types
package timer8_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL_A   = 4'h0; // [7:6] action A, [5:4] action B, [2:0] wave mode
  localparam logic [3:0] ADDR_CTRL_B   = 4'h1; // [7] force A, [6] force B, [2:0] clock source
  localparam logic [3:0] ADDR_COUNT    = 4'h2;
  localparam logic [3:0] ADDR_CMP_A    = 4'h3;
  localparam logic [3:0] ADDR_CMP_B    = 4'h4;
  localparam logic [3:0] ADDR_FLAGS    = 4'h5; // [2] compare B, [1] compare A, [0] overflow
  localparam logic [3:0] ADDR_STATUS   = 4'h6; // [1] wave B, [0] wave A

  // Field positions
  localparam int ACT_A_LSB  = 6;
  localparam int ACT_B_LSB  = 4;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMPA  = 1;
  localparam int FLAG_CMPB  = 2;

  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [2:0] CLK_STOP   = 3'h0;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_PC_FF    = 3'b001,
    MODE_CLR_MTCH = 3'b010,
    MODE_FAST_FF  = 3'b011
  } wave_mode_e;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } out_action_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic [1:0] outputActionSelA;
    logic [1:0] outputActionSelB;
    logic [2:0] waveModeSel;
    logic [2:0] clockSourceSel;
    logic [7:0] counterValue;
    logic [7:0] compareValueA;
    logic [7:0] compareValueB;
    logic       overflowFlag;
    logic       compareFlagA;
    logic       compareFlagB;
    logic       waveOutputA;
    logic       waveOutputB;
    logic       blockMatch;
    logic       pendMatchA;
    logic       pendMatchB;
    logic [7:0] rdata;
  } timer_state_s;

endpackage

// File: testbench/timer8_compare_output_ctc_assertions.sv
// Port checker for the compare timer
`timescale 1ns/1ps
module timer8_checker (
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // Timer and pins
  input wire logic       timerTick,
  input wire logic       ovfIntAck,
  input wire logic [1:0] portOutValue,
  input wire logic [1:0] wavePinDirectionBit,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  input wire logic       overflowFlag,
  input wire logic       compareFlagA
);
  logic [3:0] act_r;
  wire        flW = regWr && regAddr == timer8_pkg::ADDR_FLAGS;
  // Shadow of both action fields, so the pass-through can be judged from the ports
  always_ff @(posedge clk)
    if (!rst_b)
      act_r <= 4'h0;
    else if (regWr && regAddr == timer8_pkg::ADDR_CTRL_A)
      act_r <= regWdata[7:4];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_oe; pinOe == wavePinDirectionBit; endproperty
  property p_pass; (act_r[3:2] != 2'h0 || pinOut[0] == portOutValue[0]) &&
    (act_r[1:0] != 2'h0 || pinOut[1] == portOutValue[1]); endproperty
  property p_ovfRise; $rose(overflowFlag) |-> $past(timerTick); endproperty
  property p_cmpRise; $rose(compareFlagA) |-> $past(timerTick); endproperty
  property p_ovfFall; $fell(overflowFlag) |-> $past(ovfIntAck || flW && regWdata[0]); endproperty
  property p_clrA; flW && regWdata[1] && !timerTick |=> !compareFlagA; endproperty
  property p_ack; ovfIntAck && !timerTick |=> !overflowFlag; endproperty
  property p_rd0; !regRd |=> regRdata == 8'h00; endproperty
  a_oe: assert property (p_oe)
    else $error("pin enable differs from direction");
  a_pass: assert property (p_pass)
    else $error("pin overridden with action zero");
  a_ovfRise: assert property (p_ovfRise)
    else $error("overflow flag rose without a tick");
  a_cmpRise: assert property (p_cmpRise)
    else $error("compare flag rose without a tick");
  a_ovfFall: assert property (p_ovfFall)
    else $error("overflow flag fell without a clear");
  a_clrA: assert property (p_clrA)
    else $error("compare flag survived write one");
  a_ack: assert property (p_ack)
    else $error("overflow flag survived acknowledge");
  a_rd0: assert property (p_rd0)
    else $error("read data outside read slot");
  c_ovf: cover property ($rose(overflowFlag));
  c_cmp: cover property ($rose(compareFlagA));
  c_drive: cover property (act_r[3:2] != 2'h0 && pinOe[0]);
endmodule
bind timer8_compare_output_ctc timer8_checker chk (.*);

// File: testbench/pin_load_model.sv
// Board side of the two timer pins: wire with a pull-up
`timescale 1ns/1ps
module pin_load_model (
  // Pin drive from the timer
  input  wire logic [1:0] pinOut,
  input  wire logic [1:0] pinOe,
  // Level seen on the board
  output logic      [1:0] padLevel
);
  // An undriven pin goes to the pull-up, never keeps the last driven value
  assign padLevel = (pinOut & pinOe) | ~pinOe;
endmodule

// File: testbench/timer8_compare_output_ctc_tb_top.sv
// Self-checking bench for the compare timer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h expected %h", $time, a, b); end end
module timer8_compare_output_ctc_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        timerTick = 1'b0;
  logic        ovfIntAck = 1'b0;
  logic        cmpAIntAck = 1'b0;
  logic        cmpBIntAck = 1'b0;
  logic [1:0]  portOutValue = 2'h0;
  logic [1:0]  wavePinDirectionBit = 2'h0;
  logic [7:0]  regRdata, d, c;
  logic [1:0]  pinOut, pinOe, padLevel, a;
  logic        overflowFlag, compareFlagA, compareFlagB, w, p;
  logic [31:0] seed = 32'h00013794;
  int          mismatches = 0, comparisons = 0, n;
  timer8_compare_output_ctc dut (.*);
  pin_load_model load (.*);
  always #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic waveNext(input logic v, input logic [1:0] k);
    return k == 2'h1 ? ~v : k == 2'h2 ? 1'b0 : k == 2'h3 ? 1'b1 : v;
  endfunction
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    @(posedge clk);
    regAddr <= ad;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] ad, input logic [7:0] v);
    @(posedge clk);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(regRdata, v)
  endtask
  task automatic tick(input int k);
    repeat (k)
    begin
      @(posedge clk);
      timerTick <= 1'b1;
      @(posedge clk);
      timerTick <= 1'b0;
    end
    #1;
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic edgeWait(output int k);
    p = padLevel[0];
    k = 0;
    while (padLevel[0] === p && k < 300)
    begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 300)
    begin
      mismatches++;
      conclude();
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rdChk(timer8_pkg::ADDR_STATUS, 8'h00);
    w = 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      seed = lfsr(seed);
      a = i < 4 ? i[1:0] : seed[1:0];
      wr(timer8_pkg::ADDR_CTRL_A, {a, 6'h00});
      wr(timer8_pkg::ADDR_CTRL_B, 8'h80);
      w = waveNext(w, a);
      rdChk(timer8_pkg::ADDR_STATUS, {7'h00, w});
    end
    rdChk(timer8_pkg::ADDR_FLAGS, 8'h00);
    rdChk(timer8_pkg::ADDR_COUNT, 8'h00);
    wr(timer8_pkg::ADDR_CTRL_A, 8'hc0);
    wr(timer8_pkg::ADDR_CTRL_B, 8'h80);
    @(posedge clk);
    portOutValue <= seed[3:2];
    wavePinDirectionBit <= 2'h3;
    @(posedge clk);
    #1 `CHK(padLevel, {seed[3], 1'b1})
    wr(timer8_pkg::ADDR_CTRL_A, 8'hc2);
    rdChk(timer8_pkg::ADDR_STATUS, 8'h01);
    wr(timer8_pkg::ADDR_CTRL_A, 8'h00);
    wr(timer8_pkg::ADDR_CMP_A, 8'h10);
    wr(timer8_pkg::ADDR_COUNT, 8'h10);
    tick(5);
    rdChk(timer8_pkg::ADDR_COUNT, 8'h10);
    wr(timer8_pkg::ADDR_CTRL_B, 8'h01);
    wr(timer8_pkg::ADDR_COUNT, 8'h10);
    tick(2);
    `CHK(compareFlagA, 1'b0)
    // Count written one below compare, so the match is not lost
    wr(timer8_pkg::ADDR_COUNT, 8'h0f);
    tick(2);
    `CHK(compareFlagA, 1'b0)
    tick(1);
    `CHK(compareFlagA, 1'b1)
    wr(timer8_pkg::ADDR_FLAGS, 8'h02);
    rdChk(timer8_pkg::ADDR_FLAGS, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      wr(timer8_pkg::ADDR_CTRL_A, {6'h00, m[0], 1'b0});
      wr(timer8_pkg::ADDR_CMP_A, 8'h05);
      wr(timer8_pkg::ADDR_COUNT, 8'hfe);
      tick(1);
      `CHK(overflowFlag, 1'b0)
      tick(1);
      `CHK(overflowFlag, 1'b1)
      rdChk(timer8_pkg::ADDR_COUNT, 8'h00);
      if (m == 0)
        wr(timer8_pkg::ADDR_FLAGS, 8'h01);
      else
        tick(0);
      @(posedge clk);
      ovfIntAck <= m[0];
      @(posedge clk);
      ovfIntAck <= 1'b0;
      #1 `CHK(overflowFlag, 1'b0)
    end
    // Small top keeps each period short
    c = {4'h0, seed[7:4]};
    wr(timer8_pkg::ADDR_CTRL_A, 8'h42);
    wr(timer8_pkg::ADDR_CMP_A, c);
    @(posedge clk);
    timerTick <= 1'b1;
    edgeWait(n);
    edgeWait(n);
    `CHK(n, c + 1)
    `CHK(compareFlagA, 1'b1)
    `CHK(compareFlagB, 1'b1)
    // Stop the clock first, otherwise a pending match would set the flags again
    wr(timer8_pkg::ADDR_CTRL_B, 8'h00);
    @(posedge clk);
    cmpAIntAck <= 1'b1;
    cmpBIntAck <= 1'b1;
    @(posedge clk);
    cmpAIntAck <= 1'b0;
    cmpBIntAck <= 1'b0;
    #1 `CHK(compareFlagA, 1'b0)
    `CHK(compareFlagB, 1'b0)
    conclude();
  end
endmodule
